// ==== common/dhwi_pkg.sv ====
// Purpose: Shared constants and types of the converter host write front end.
// Assumes: Pins arrive asynchronous to clk and are synchronised in the top.
// Notes: Serial word is 24 bits, type, address and data, most significant bit first.
package dhwi_pkg;
    // Word and address geometry
    localparam int DATA_W = 14;
    localparam int ADDR_W = 8;
    localparam int NUM_GROUPS = 4;
    localparam int CH_PER_GROUP = 10;
    localparam int SER_WORD_BITS = 24;
    localparam int SER_CNT_W = 5;
    localparam logic [SER_CNT_W-1:0] SER_CNT_FULL = 5'h18;
    // Serial word field positions
    localparam int SER_TYPE_MSB = 23;
    localparam int SER_TYPE_LSB = 22;
    localparam int SER_ADDR_MSB = 21;
    localparam int SER_ADDR_LSB = 14;
    localparam int SER_DATA_MSB = 13;
    // Address decode values
    localparam logic [3:0] GRP_ALL = 4'h4;
    localparam logic [3:0] CH_LAST = 4'h9;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'hFF;
    localparam logic [NUM_GROUPS-1:0] GRP_MASK_ALL = 4'hF;
    localparam logic [NUM_GROUPS-1:0] GRP_MASK_ONE = 4'h1;
    // Serial clock limit and sampling margin at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int SCLK_MAX_MHZ = 30;
    localparam int SCLK_MIN_HALF_CYC = CLK_MHZ / (2 * SCLK_MAX_MHZ);

    typedef enum logic [1:0] {
        KIND_SPECIAL = 2'h0,
        KIND_GAIN = 2'h1,
        KIND_OFFSET = 2'h2,
        KIND_DATA = 2'h3
    } dhwi_kind_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'h0,
        SER_SHIFT = 2'h1,
        SER_DONE = 2'h3
    } dhwi_ser_state_t;

    typedef struct packed {
        logic ok;
        logic soft_reset;
        dhwi_kind_t kind;
        logic [NUM_GROUPS-1:0] grp_mask;
        logic [3:0] chan;
        logic [DATA_W-1:0] data;
    } dhwi_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic type_hi;
        logic type_lo;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dhwi_par_pins_t;

    typedef struct packed {
        logic interface_select;
        logic chain_enable;
        logic busy_n;
        logic reset_n;
        logic sync_n;
        logic sclk;
        logic sdin;
    } dhwi_ctl_pins_t;
endpackage

// ==== hw/dhwi_sync.sv ====
// Purpose: Two flip-flop synchroniser for a bundle of asynchronous pins.
// Assumes: Bits of a bundle are independent levels or held stable around use.
// Notes: First stage is read only by the second stage.
`timescale 1ns/10ps
module dhwi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bundle in and out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // Two stage capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ==== hw/dhwi_top.sv ====
// Purpose: Host write front end, serial and parallel ports into one command strobe.
// Assumes: Serial clock at most 30 MHz, so each phase spans two or more clk cycles.
// Notes: Commands leave as one-cycle strobes with a decoded target.
`timescale 1ns/10ps
module dhwi_top
    import dhwi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Mode straps and status pins
    input wire logic interface_select,
    input wire logic chain_enable,
    input wire logic busy_n,
    input wire logic reset_n,
    // Serial port
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic sdin,
    output logic serial_data_out,
    // Parallel port
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic [DATA_W-1:0] par_data_bus,
    input wire logic [ADDR_W-1:0] channel_addr,
    input wire logic reg_type_sel_lo,
    input wire logic reg_type_sel_hi,
    // Decoded write out
    output logic wr_stb,
    output dhwi_cmd_t wr_cmd,
    output logic soft_reset_stb
);
    // Decode type, address and data into a command
    function automatic dhwi_cmd_t decode_cmd(input logic [1:0] typ,
                                             input logic [ADDR_W-1:0] addr,
                                             input logic [DATA_W-1:0] data);
        dhwi_cmd_t c;
        logic [3:0] grp;
        logic [3:0] ch;
        grp = addr[7:4];
        ch = addr[3:0];
        c.kind = dhwi_kind_t'(typ);
        c.data = data;
        c.chan = ch;
        c.soft_reset = (c.kind == KIND_SPECIAL) && (addr == ADDR_SOFT_RESET);
        if (grp < GRP_ALL) begin
            c.grp_mask = GRP_MASK_ONE << grp[1:0];
        end else if (grp == GRP_ALL) begin
            c.grp_mask = GRP_MASK_ALL;
        end else begin
            c.grp_mask = '0;
        end
        c.ok = !c.soft_reset && (c.grp_mask != '0) && (ch <= CH_LAST);
        return c;
    endfunction

    // Synchronised pin bundles
    dhwi_ctl_pins_t ctl_async;
    dhwi_ctl_pins_t ctl_s;
    dhwi_par_pins_t par_async;
    dhwi_par_pins_t par_s;

    assign ctl_async = '{interface_select: interface_select, chain_enable: chain_enable,
                         busy_n: busy_n, reset_n: reset_n, sync_n: sync_n,
                         sclk: sclk, sdin: sdin};
    assign par_async = '{cs_n: cs_n, wr_n: wr_n, type_hi: reg_type_sel_hi,
                         type_lo: reg_type_sel_lo, addr: channel_addr, data: par_data_bus};

    dhwi_sync #(.WIDTH($bits(dhwi_ctl_pins_t))) u_ctl_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(ctl_async),
        .sync_out(ctl_s)
    );

    dhwi_sync #(.WIDTH($bits(dhwi_par_pins_t))) u_par_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(par_async),
        .sync_out(par_s)
    );

    // Edge history, idle levels are high
    logic sclk_prev_reg;
    logic wr_n_prev_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_prev_reg <= 1'b1;
            wr_n_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= ctl_s.sclk;
            wr_n_prev_reg <= par_s.wr_n;
        end
    end

    // Synchroniser flush after reset looks like pin edges, so edges wait for it
    logic [1:0] settle_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            settle_reg <= 2'h0;
        end else if (!(&settle_reg)) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    // Mode and edge decode
    wire edges_ok = &settle_reg;
    wire serial_mode = ctl_s.interface_select;
    wire parallel_mode = !ctl_s.interface_select;
    wire chain_mode = ctl_s.chain_enable && ctl_s.interface_select;
    wire sclk_fall = edges_ok && sclk_prev_reg && !ctl_s.sclk;
    wire sclk_rise = edges_ok && !sclk_prev_reg && ctl_s.sclk;
    wire wr_rise = edges_ok && !wr_n_prev_reg && par_s.wr_n;
    wire par_disabled = !ctl_s.busy_n || !ctl_s.reset_n;
    wire par_take = parallel_mode && !par_s.cs_n && wr_rise && !par_disabled;

    // Serial receive state
    dhwi_ser_state_t ser_state_reg;
    dhwi_ser_state_t ser_state_next;
    logic [SER_WORD_BITS-1:0] shift_reg;
    logic [SER_WORD_BITS-1:0] shift_next;
    logic [SER_CNT_W-1:0] bit_cnt_reg;
    logic [SER_CNT_W-1:0] bit_cnt_next;

    // Serial frame sequencing
    always_comb begin
        ser_state_next = ser_state_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        case (ser_state_reg)
            SER_IDLE: begin
                if (serial_mode && !ctl_s.sync_n) begin
                    ser_state_next = SER_SHIFT;
                    bit_cnt_next = '0;
                    if (sclk_fall) begin
                        shift_next = {shift_reg[SER_WORD_BITS-2:0], ctl_s.sdin};
                        bit_cnt_next = SER_CNT_W'(1);
                    end
                end
            end
            SER_SHIFT: begin
                if (!serial_mode) begin
                    ser_state_next = SER_IDLE;
                end else if (ctl_s.sync_n) begin
                    ser_state_next = (bit_cnt_reg == SER_CNT_FULL) ? SER_DONE : SER_IDLE;
                end else if (sclk_fall) begin
                    shift_next = {shift_reg[SER_WORD_BITS-2:0], ctl_s.sdin};
                    if (bit_cnt_reg != SER_CNT_FULL) begin
                        bit_cnt_next = bit_cnt_reg + SER_CNT_W'(1);
                    end
                end
            end
            SER_DONE: begin
                ser_state_next = SER_IDLE;
            end
            default: begin
                ser_state_next = SER_IDLE;
            end
        endcase
    end

    // Serial state registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ser_state_reg <= SER_IDLE;
            shift_reg <= '0;
            bit_cnt_reg <= '0;
        end else begin
            ser_state_reg <= ser_state_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Chained serial output, updated on serial clock rise
    logic sdo_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdo_reg <= 1'b0;
        end else if (!chain_mode) begin
            sdo_reg <= 1'b0;
        end else if (sclk_rise) begin
            sdo_reg <= shift_reg[SER_WORD_BITS-1];
        end
    end

    assign serial_data_out = sdo_reg;

    // Command source selection
    wire ser_take = ser_state_reg == SER_DONE;
    wire [1:0] ser_type = shift_reg[SER_TYPE_MSB:SER_TYPE_LSB];
    wire [ADDR_W-1:0] ser_addr = shift_reg[SER_ADDR_MSB:SER_ADDR_LSB];
    wire [DATA_W-1:0] ser_data = shift_reg[SER_DATA_MSB:0];
    wire [1:0] par_type = {par_s.type_hi, par_s.type_lo};
    wire dhwi_cmd_t ser_cmd = decode_cmd(ser_type, ser_addr, ser_data);
    wire dhwi_cmd_t par_cmd = decode_cmd(par_type, par_s.addr, par_s.data);
    wire dhwi_cmd_t new_cmd = ser_take ? ser_cmd : par_cmd;
    wire take_any = ser_take || par_take;

    // Output strobes and held command
    logic wr_stb_reg;
    logic soft_reset_reg;
    dhwi_cmd_t wr_cmd_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_stb_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            wr_cmd_reg <= '0;
        end else begin
            wr_stb_reg <= take_any && new_cmd.ok;
            soft_reset_reg <= take_any && new_cmd.soft_reset;
            if (take_any && new_cmd.ok) begin
                wr_cmd_reg <= new_cmd;
            end
        end
    end

    assign wr_stb = wr_stb_reg;
    assign wr_cmd = wr_cmd_reg;
    assign soft_reset_stb = soft_reset_reg;
endmodule

// ==== tb/dhwi_asserts.sv ====
// Purpose: Port checks of the host write front end.
// Assumes: Pins held four cycles around each write.
// Notes: Outputs trail the pins by three cycles.
`timescale 1ns/10ps
module dhwi_chk
    import dhwi_pkg::*;
(
    // Clock, reset and straps
    input wire logic clk, sys_rst, interface_select, chain_enable, busy_n, reset_n,
    // Serial and parallel pins
    input wire logic sclk, serial_data_out, cs_n, reg_type_sel_lo, reg_type_sel_hi,
    input wire logic [DATA_W-1:0] par_data_bus,
    input wire logic [ADDR_W-1:0] channel_addr,
    // Decoded write
    input wire logic wr_stb,
    input wire dhwi_cmd_t wr_cmd
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Parallel write leaving the block
    sequence s_par;
        wr_stb && !interface_select;
    endsequence
    // Strobe shape and command hold
    property p_pulse; wr_stb |=> !wr_stb; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_hold; !wr_stb |-> $stable(wr_cmd); endproperty
    a_hold: assert property (p_hold) else $error("command moved");
    // Parallel capture against the pins
    property p_cs; s_par |-> $past(cs_n, 3) == 1'b0; endproperty
    a_cs: assert property (p_cs) else $error("write without select");
    property p_busy; s_par |-> $past(busy_n, 3) && $past(reset_n, 3); endproperty
    a_busy: assert property (p_busy) else $error("write while held");
    property p_kind;
        s_par |-> wr_cmd.kind == {$past(reg_type_sel_hi, 3), $past(reg_type_sel_lo, 3)};
    endproperty
    a_kind: assert property (p_kind) else $error("wrong kind");
    property p_chan;
        s_par |-> wr_cmd.chan == ($past(channel_addr, 3) & 8'h0F) && wr_cmd.chan <= CH_LAST;
    endproperty
    a_chan: assert property (p_chan) else $error("wrong channel");
    property p_data; s_par |-> wr_cmd.data == $past(par_data_bus, 3); endproperty
    a_data: assert property (p_data) else $error("wrong data");
    // Chain output
    property p_sdo; !(interface_select && chain_enable) [*6] |-> !serial_data_out; endproperty
    a_sdo: assert property (p_sdo) else $error("chain out active");
    property p_rise;
        $changed(serial_data_out) && interface_select && chain_enable |-> $past(sclk, 2);
    endproperty
    a_rise: assert property (p_rise) else $error("chain out off edge");
endmodule

// ==== tb/dhwi_host.sv ====
// Purpose: Host driver for both write ports.
// Assumes: Serial clock idles high between frames.
// Notes: Released data lines are inverted.
`timescale 1ns/10ps
module dhwi_host
    import dhwi_pkg::*;
(
    // Clock and chain data back
    input wire logic clk, serial_data_out,
    // Pins toward the device
    output dhwi_par_pins_t par,
    output dhwi_ctl_pins_t ctl
);
    logic [SER_WORD_BITS-1:0] sdo_seen;
    // Idle pins at time zero
    initial begin
        par = {1'b1, 1'b1, 2'h3, 8'h00, 14'h0000};
        ctl = 7'h1E;
    end
    // Step to just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Parallel write, pins held around the strobe
    task automatic pwr(input logic c, input logic [1:0] t, input logic [7:0] a,
                       input logic [13:0] d);
        par = {c, 1'b1, t, a, d};
        tick(4);
        par.wr_n = 1'b0;
        tick(4);
        par.wr_n = 1'b1;
        tick(5);
        par.cs_n = 1'b1;
        par.data = ~d;
        tick(1);
    endtask
    // Serial frame, chain data sampled at each fall
    task automatic sfr(input logic [23:0] w, input int n);
        ctl.sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #31.25 ctl.sdin = w[23-i];
            #31.25 sdo_seen[23-i] = serial_data_out;
            ctl.sclk = 1'b0;
            #62.5 ctl.sclk = 1'b1;
        end
        #62.5 ctl.sync_n = 1'b1;
        ctl.sdin = ~ctl.sdin;
        tick(8);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench of the host write front end.
// Assumes: Host model paces both ports.
// Notes: A monitor counts strobes for comparison.
`timescale 1ns/10ps
module testbench;
    import dhwi_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic serial_data_out, wr_stb, soft_reset_stb;
    dhwi_par_pins_t par;
    dhwi_ctl_pins_t ctl;
    dhwi_cmd_t wr_cmd, last_cmd;
    logic [25:0] n_stb = 26'h0, n_srst = 26'h0, e_stb = 26'h0;
    int errors = 0;
    int n_tests = 0;
    // Clock
    always #4 clk = ~clk;
    // Count strobes, keep last command
    always @(posedge clk) begin
        if (wr_stb === 1'b1) begin
            n_stb <= n_stb + 26'h1;
            last_cmd <= wr_cmd;
        end
        if (soft_reset_stb === 1'b1) begin
            n_srst <= n_srst + 26'h1;
        end
    end
    dhwi_host u_host (.clk(clk), .serial_data_out(serial_data_out), .par(par), .ctl(ctl));
    dhwi_top u_dut (.clk(clk), .sys_rst(sys_rst), .interface_select(ctl.interface_select),
        .chain_enable(ctl.chain_enable), .busy_n(ctl.busy_n), .reset_n(ctl.reset_n),
        .sync_n(ctl.sync_n), .sclk(ctl.sclk), .sdin(ctl.sdin),
        .serial_data_out(serial_data_out), .cs_n(par.cs_n), .wr_n(par.wr_n),
        .par_data_bus(par.data), .channel_addr(par.addr), .reg_type_sel_lo(par.type_lo),
        .reg_type_sel_hi(par.type_hi), .wr_stb(wr_stb), .wr_cmd(wr_cmd),
        .soft_reset_stb(soft_reset_stb));
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [25:0] s, input logic [25:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Expected command of an accepted write
    function automatic dhwi_cmd_t ex(input logic [23:0] w);
        return {1'b1, 1'b0, w[23:22],
                w[21:18] == GRP_ALL ? GRP_MASK_ALL : GRP_MASK_ONE << w[21:18], w[17:0]};
    endfunction
    // One write on either port and its check
    task automatic go(input logic ser, input logic c, input logic [23:0] w, input int n,
                      input logic ok);
        if (ser) begin
            u_host.sfr(w, n);
        end else begin
            u_host.pwr(c, w[23:22], w[21:14], w[13:0]);
        end
        e_stb = e_stb + {25'h0, ok};
        chk(n_stb, e_stb);
        if (ok) begin
            chk(last_cmd, ex(w));
        end
    endtask
    // Watchdog
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        u_host.tick(4);
        for (int i = 0; i < 5; i++) begin
            go(0, 0, {2'(i), 4'(i), 4'(9 - 2 * i), 14'h2001 << i}, 0, 1);
        end
        go(0, 0, 24'hC28D15, 0, 0);
        go(0, 0, 24'hD40D15, 0, 0);
        go(0, 1, 24'hC00D15, 0, 0);
        u_host.ctl.busy_n = 1'b0;
        go(0, 0, 24'hC44ABC, 0, 0);
        u_host.ctl.busy_n = 1'b1;
        u_host.ctl.reset_n = 1'b0;
        go(0, 0, 24'hC44ABC, 0, 0);
        u_host.ctl.reset_n = 1'b1;
        go(0, 0, 24'h3FC000, 0, 0);
        chk(n_srst, 26'h1);
        u_host.ctl.interface_select = 1'b1;
        u_host.tick(8);
        go(0, 0, 24'hC88155, 0, 0);
        go(1, 0, 24'hC23FFE, 24, 1);
        go(1, 0, 24'h805555, 23, 0);
        u_host.ctl.chain_enable = 1'b1;
        go(1, 0, 24'h449876, 24, 1);
        go(1, 0, 24'hC1000F, 24, 1);
        chk(u_host.sdo_seen, 24'h449876);
        u_host.ctl.chain_enable = 1'b0;
        u_host.ctl.interface_select = 1'b0;
        u_host.tick(8);
        chk(serial_data_out, 1'b0);
        go(1, 0, 24'hC23FFE, 24, 0);
        give_verdict();
    end
endmodule
bind dhwi_top dhwi_chk u_chk (.*);
